// ---- hw/pic_defines.vh ----
/*
  pic_defines.vh: register offsets, field positions, reset values and timing
  counts for the priority interrupt controller.
  assumes: included by its bare name from the design files under hw/.
*/
`ifndef PRIC_DEFINES_VH
`define PRIC_DEFINES_VH

// register byte offsets on the axi4-lite bus
`define PRIC_CTRL_OFS       8'h00
`define PRIC_FLAG_OFS       8'h04
`define PRIC_ENABLE_OFS     8'h08
`define PRIC_PRIO0_OFS      8'h0c
`define PRIC_PRIO6_OFS      8'h10
`define PRIC_PERIPH_OFS     8'h14
`define PRIC_STATUS_OFS     8'h18

// control register fields
`define PRIC_CTRL_GHE_BIT   0
`define PRIC_CTRL_PLE_BIT   1
`define PRIC_CTRL_PME_BIT   2
`define PRIC_CTRL_EDG_LSB   4

// source map: bits 2..0 external inputs, bits 4..3 capture/compare 2..1
`define PRIC_NSRC           5
`define PRIC_NEXT           3
`define PRIC_CAP1_IDX       3
`define PRIC_CAP2_IDX       4

// reset values
`define PRIC_CTRL_RST       8'h70
`define PRIC_PRIO0_RST      3'h7
`define PRIC_PRIO6_RST      2'h3
`define PRIC_PERIPH_RST     5'h18

// vectors
`define PRIC_VEC_HIGH       21'h000008
`define PRIC_VEC_LOW        21'h000018

// event-to-vector latency in instruction cycles, fixed for all instructions
`define PRIC_LATENCY_CYC    3

// axi responses
`define PRIC_RESP_OKAY      2'h0
`define PRIC_RESP_SLVERR    2'h2

`endif

// ---- hw/pric_edge_det.v ----
/*
  pric_edge_det.v: one external input with selectable edge detection.
  assumes: input already synchronous to the clock; ce freezes state.
*/
`timescale 1ns/10ps
`include "pic_defines.vh"

module pric_edge_det (
  input  wire clk_in,
  input  wire rst_in,
  input  wire ce_in,
  input  wire pin_in,
  input  wire rise_sel_in,
  output wire edge_out
);
  reg prev_reg;

  always @(posedge clk_in) begin
    if (rst_in) begin
      prev_reg <= 1'b0;
    end else if (ce_in) begin
      prev_reg <= pin_in;
    end
  end

  assign edge_out = ce_in & (rise_sel_in ? (pin_in & ~prev_reg) : (~pin_in & prev_reg)); // RL17
endmodule // pric_edge_det

// ---- hw/pric_delay.v ----
/*
  pric_delay.v: fixed-length pulse delay line.
  assumes: pulses are single cycle; ce freezes the line.
*/
`timescale 1ns/10ps

module pric_delay #(
  parameter DEPTH = 3
) (
  input  wire clk_in,
  input  wire rst_in,
  input  wire ce_in,
  input  wire d_in,
  output wire q_out
);
  reg [DEPTH-1:0] line_reg;

  always @(posedge clk_in) begin
    if (rst_in) begin
      line_reg <= {DEPTH{1'b0}};
    end else if (ce_in) begin
      line_reg <= {line_reg[DEPTH-2:0], d_in};
    end
  end

  assign q_out = line_reg[DEPTH-1];
endmodule // pric_delay

// ---- hw/pric_top.v ----
/*
  pric_top.v: two-level priority interrupt controller with axi4-lite registers.
  assumes: one clock, synchronous active-high reset, inputs synchronous to the
  clock, core pulses accept/return strobes as it takes or leaves a vector.
*/
`timescale 1ns/10ps
`include "pic_defines.vh"

// What this block does
// RL1: high vector 0008h and low vector 0018h when priority levels are used.
// RL2: pending high request preempts a running low routine.
// RL3: every source has its own flag, enable and priority bit.
// RL4: priority mode enable clear by default; priority bits then ignored.
// RL5: compatibility: peripheral enable gates peripherals, also needs global enable.
// RL6: compatibility: global enable permits non-peripherals; clear blocks everything.
// RL7: compatibility: every accepted interrupt vectors to 0008h.
// RL8: priority mode: high enable permits high sources; clear blocks all.
// RL9: priority mode: low sources need both high and low enables.
// RL10: accepting clears the global enable of that level.
// RL11: low requests held off while a high routine runs.
// RL12: accept pushes return address and loads the vector.
// RL13: return instruction leaves routine and sets the cleared enable again.
// RL14: external event to vector latency fixed at three to four cycles.
// RL15: flags set on events regardless of any enable.
// RL16: software clears flags before re-enabling interrupts.
// RL17: three external inputs, edge select one rising, zero falling.
// RL18: enabled external interrupt wakes; vectors only if global enable set.
// RL19: external priorities come from priority register 0 bits.
// RL20: software avoids file-to-file moves on control registers while enabled.
// RL21: priority register 6: bit1 capture 2, bit0 capture 1, reset ones.
// RL22: simultaneous high and low requests: high accepted first.
module pric_top #(
  parameter LATENCY = `PRIC_LATENCY_CYC
) (
  // clock, reset, enable
  input  wire        MCLK_IN,
  input  wire        RST_IN,
  input  wire        CE_IN,
  // event sources
  input  wire [2:0]  EXT_PIN_IN,
  input  wire        CAP1_EVENT_IN,
  input  wire        CAP2_EVENT_IN,
  // core side
  input  wire        SLEEP_IN,
  input  wire        RETURN_IN,
  input  wire        ACCEPT_IN,
  input  wire [20:0] RETURN_ADDR_IN,
  output reg         IRQ_OUT,
  output reg  [20:0] VECTOR_OUT,
  output reg         PUSH_OUT,
  output reg  [20:0] PUSH_ADDR_OUT,
  output reg         WAKE_OUT,
  // axi4-lite slave
  input  wire [7:0]  AWADDR_IN,
  input  wire        AWVALID_IN,
  output reg         AWREADY_OUT,
  input  wire [31:0] WDATA_IN,
  input  wire [3:0]  WSTRB_IN,
  input  wire        WVALID_IN,
  output reg         WREADY_OUT,
  output reg  [1:0]  BRESP_OUT,
  output reg         BVALID_OUT,
  input  wire        BREADY_IN,
  input  wire [7:0]  ARADDR_IN,
  input  wire        ARVALID_IN,
  output reg         ARREADY_OUT,
  output reg  [31:0] RDATA_OUT,
  output reg  [1:0]  RRESP_OUT,
  output reg         RVALID_OUT,
  input  wire        RREADY_IN
);
  localparam NS = `PRIC_NSRC;
  // state codes also read back through the status register
  localparam ST_IDLE = 2'h0;
  localparam ST_LOW  = 2'h1;
  localparam ST_HIGH = 2'h2;

  // registers
  reg [7:0]    ctrl_reg;
  reg [NS-1:0] flag_reg;
  reg [NS-1:0] enable_reg;
  reg [2:0]    prio0_reg;
  reg [1:0]    prio6_reg;
  reg [NS-1:0] periph_reg;
  reg [1:0]    state_reg;
  reg          nested_low_reg;
  reg          pend_high_reg;
  reg          sleeping_reg;

  // bus staging
  reg [7:0]  aw_addr_reg;
  reg        aw_have_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;
  reg        w_have_reg;

  wire ghe = ctrl_reg[`PRIC_CTRL_GHE_BIT];
  wire ple = ctrl_reg[`PRIC_CTRL_PLE_BIT];
  wire pme = ctrl_reg[`PRIC_CTRL_PME_BIT];

  // edge detection and latency shaping for external inputs
  wire [2:0] ext_edge;
  wire [2:0] ext_evt;
  genvar gi;
  generate
    for (gi = 0; gi < `PRIC_NEXT; gi = gi + 1) begin : g_ext
      // edge select is read live; changing it alone does not make an edge
      pric_edge_det u_edge (
        .clk_in      (MCLK_IN),
        .rst_in      (RST_IN),
        .ce_in       (CE_IN),
        .pin_in      (EXT_PIN_IN[gi]),
        .rise_sel_in (ctrl_reg[`PRIC_CTRL_EDG_LSB+gi]),
        .edge_out    (ext_edge[gi])
      );
      // fixed depth keeps latency independent of the instruction stream
      pric_delay #(.DEPTH(LATENCY)) u_dly (
        .clk_in (MCLK_IN),
        .rst_in (RST_IN),
        .ce_in  (CE_IN),
        .d_in   (ext_edge[gi]),
        .q_out  (ext_evt[gi])
      ); // RL14
    end
  endgenerate

  wire [NS-1:0] events = {CAP2_EVENT_IN, CAP1_EVENT_IN, ext_evt};
  // priority bits line up one to one with the source order of events
  wire [NS-1:0] prio   = {prio6_reg, prio0_reg}; // RL19 RL21
  wire [NS-1:0] active = flag_reg & enable_reg; // RL3

  // level qualification
  reg  [NS-1:0] hi_src;
  reg  [NS-1:0] lo_src;
  always @* begin
    if (!pme) begin
      // priority bits ignored; all go through the single level
      hi_src = active & ~periph_reg & {NS{ghe}}; // RL4 RL6
      hi_src = hi_src | (active & periph_reg & {NS{ghe & ple}}); // RL5
      lo_src = {NS{1'b0}};
    end else begin
      hi_src = active & prio & {NS{ghe}}; // RL8
      lo_src = active & ~prio & {NS{ghe & ple}}; // RL9
    end
  end

  wire hi_req = |hi_src;
  // low entry only from idle, so a running high routine holds it off even if re-enabled
  wire lo_req = (|lo_src) && (state_reg == ST_IDLE); // RL11
  // wake uses the raw edge, not the delayed event, so the core restarts early
  wire ext_wake = |(ext_edge & enable_reg[2:0]);

  // bus decode
  wire aw_take = AWVALID_IN && AWREADY_OUT;
  wire w_take  = WVALID_IN && WREADY_OUT;
  wire [7:0]  wr_addr = aw_have_reg ? aw_addr_reg : AWADDR_IN;
  wire [31:0] wr_data = w_have_reg ? w_data_reg : WDATA_IN;
  wire [3:0]  wr_strb = w_have_reg ? w_strb_reg : WSTRB_IN;
  // address and data may arrive in either order; the response waits for both
  wire wr_go = (aw_have_reg || aw_take) && (w_have_reg || w_take) && !BVALID_OUT;
  wire wr_lane = wr_go && wr_strb[0];
  wire wr_ok = (wr_addr == `PRIC_CTRL_OFS) || (wr_addr == `PRIC_FLAG_OFS) ||
               (wr_addr == `PRIC_ENABLE_OFS) || (wr_addr == `PRIC_PRIO0_OFS) ||
               (wr_addr == `PRIC_PRIO6_OFS) || (wr_addr == `PRIC_PERIPH_OFS) ||
               (wr_addr == `PRIC_STATUS_OFS);

  // unmapped reads answer zero with an error response
  reg [31:0] rd_data;
  reg        rd_ok;
  always @* begin
    rd_ok = 1'b1;
    case (ARADDR_IN)
      `PRIC_CTRL_OFS:   rd_data = {24'h000000, ctrl_reg};
      `PRIC_FLAG_OFS:   rd_data = {27'h0000000, flag_reg};
      `PRIC_ENABLE_OFS: rd_data = {27'h0000000, enable_reg};
      `PRIC_PRIO0_OFS:  rd_data = {29'h00000000, prio0_reg};
      `PRIC_PRIO6_OFS:  rd_data = {30'h00000000, prio6_reg}; // RL21
      `PRIC_PERIPH_OFS: rd_data = {27'h0000000, periph_reg};
      `PRIC_STATUS_OFS: rd_data = {28'h0000000, sleeping_reg, nested_low_reg, state_reg};
      default: begin
        rd_data = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // write channels
  always @(posedge MCLK_IN) begin
    if (RST_IN) begin
      AWREADY_OUT <= 1'b0;
      WREADY_OUT  <= 1'b0;
      BVALID_OUT  <= 1'b0;
      BRESP_OUT   <= `PRIC_RESP_OKAY;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
    end else if (CE_IN) begin
      // ready stays low while a response waits: one write in flight at a time
      AWREADY_OUT <= !aw_have_reg && !aw_take && !BVALID_OUT;
      WREADY_OUT  <= !w_have_reg && !w_take && !BVALID_OUT;
      if (wr_go) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        AWREADY_OUT <= 1'b0;
        WREADY_OUT  <= 1'b0;
        BVALID_OUT  <= 1'b1;
        BRESP_OUT   <= wr_ok ? `PRIC_RESP_OKAY : `PRIC_RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_have_reg <= 1'b1;
          aw_addr_reg <= AWADDR_IN;
        end
        if (w_take) begin
          w_have_reg <= 1'b1;
          w_data_reg <= WDATA_IN;
          w_strb_reg <= WSTRB_IN;
        end
        if (BVALID_OUT && BREADY_IN) begin
          BVALID_OUT <= 1'b0;
        end
      end
    end
  end

  // read channel
  always @(posedge MCLK_IN) begin
    if (RST_IN) begin
      ARREADY_OUT <= 1'b0;
      RVALID_OUT  <= 1'b0;
      RDATA_OUT   <= 32'h00000000;
      RRESP_OUT   <= `PRIC_RESP_OKAY;
    end else if (CE_IN) begin
      // the address is taken only while no read data waits
      ARREADY_OUT <= !RVALID_OUT && !(ARVALID_IN && ARREADY_OUT);
      if (ARVALID_IN && ARREADY_OUT) begin
        ARREADY_OUT <= 1'b0;
        RVALID_OUT  <= 1'b1;
        RDATA_OUT   <= rd_data;
        RRESP_OUT   <= rd_ok ? `PRIC_RESP_OKAY : `PRIC_RESP_SLVERR;
      end else if (RVALID_OUT && RREADY_IN) begin
        RVALID_OUT <= 1'b0;
      end
    end
  end

  // registers written by software and by hardware
  reg [7:0]    ctrl_next;
  reg [NS-1:0] flag_next;
  always @* begin
    ctrl_next = ctrl_reg;
    flag_next = flag_reg;
    if (wr_lane && wr_addr == `PRIC_CTRL_OFS) begin
      ctrl_next = {1'b0, wr_data[6:4], 1'b0, wr_data[2:0]};
    end
    if (wr_lane && wr_addr == `PRIC_FLAG_OFS) begin
      flag_next = wr_data[NS-1:0];
    end
    // accept clears the enable of the level being entered
    if (ACCEPT_IN && IRQ_OUT) begin
      if (!pme || pend_high_reg) begin
        ctrl_next[`PRIC_CTRL_GHE_BIT] = 1'b0; // RL10
      end else begin
        ctrl_next[`PRIC_CTRL_PLE_BIT] = 1'b0; // RL10
      end
    end
    // a return restores only the enable of the level being left
    if (RETURN_IN && state_reg != ST_IDLE) begin
      if (!pme || state_reg == ST_HIGH) begin
        ctrl_next[`PRIC_CTRL_GHE_BIT] = 1'b1; // RL13
      end else begin
        ctrl_next[`PRIC_CTRL_PLE_BIT] = 1'b1; // RL13
      end
    end
    // hardware set wins over a software clear in the same cycle
    flag_next = flag_next | events; // RL15
  end

  always @(posedge MCLK_IN) begin
    if (RST_IN) begin
      ctrl_reg       <= `PRIC_CTRL_RST; // RL4
      flag_reg       <= {NS{1'b0}};
      enable_reg     <= {NS{1'b0}};
      prio0_reg      <= `PRIC_PRIO0_RST;
      prio6_reg      <= `PRIC_PRIO6_RST; // RL21
      periph_reg     <= `PRIC_PERIPH_RST;
      state_reg      <= ST_IDLE;
      nested_low_reg <= 1'b0;
      pend_high_reg  <= 1'b0;
      sleeping_reg   <= 1'b0;
      IRQ_OUT        <= 1'b0;
      VECTOR_OUT     <= `PRIC_VEC_HIGH;
      PUSH_OUT       <= 1'b0;
      PUSH_ADDR_OUT  <= 21'h000000;
      WAKE_OUT       <= 1'b0;
    end else if (CE_IN) begin
      ctrl_reg <= ctrl_next;
      flag_reg <= flag_next;
      if (wr_lane && wr_addr == `PRIC_ENABLE_OFS) enable_reg <= wr_data[NS-1:0];
      if (wr_lane && wr_addr == `PRIC_PRIO0_OFS) prio0_reg <= wr_data[2:0]; // RL19
      if (wr_lane && wr_addr == `PRIC_PRIO6_OFS) prio6_reg <= wr_data[1:0]; // RL21
      if (wr_lane && wr_addr == `PRIC_PERIPH_OFS) periph_reg <= wr_data[NS-1:0];
      // request toward core; high wins any tie
      IRQ_OUT <= (hi_req || lo_req) && !(ACCEPT_IN && IRQ_OUT) && !sleeping_reg;
      // the level latched here travels with IRQ_OUT and VECTOR_OUT, so the accept
      // that follows decodes the same level that the core was shown
      pend_high_reg <= hi_req;
      if (hi_req || !pme) begin
        VECTOR_OUT <= `PRIC_VEC_HIGH; // RL1 RL7 RL22
      end else begin
        VECTOR_OUT <= `PRIC_VEC_LOW; // RL1
      end
      // push and its address leave together one cycle after the accept edge
      PUSH_OUT <= ACCEPT_IN && IRQ_OUT; // RL12
      if (ACCEPT_IN && IRQ_OUT) begin
        PUSH_ADDR_OUT <= RETURN_ADDR_IN; // RL12
        if (pend_high_reg || !pme) begin
          // a high entry over a running low routine is remembered for the return
          nested_low_reg <= (state_reg == ST_LOW); // RL2
          state_reg      <= ST_HIGH;
        end else begin
          state_reg <= ST_LOW;
        end
      end else if (RETURN_IN) begin
        case (state_reg)
          ST_HIGH: begin
            state_reg      <= nested_low_reg ? ST_LOW : ST_IDLE;
            nested_low_reg <= 1'b0;
          end
          ST_LOW:  state_reg <= ST_IDLE;
          default: state_reg <= ST_IDLE;
        endcase
      end
      // wake on enabled edge; vectoring then follows the global enable
      WAKE_OUT <= sleeping_reg && ext_wake; // RL18
      // sleep entry wins over a wake edge in the same cycle; that edge is lost
      if (SLEEP_IN) begin
        sleeping_reg <= 1'b1;
      end else if (ext_wake) begin
        sleeping_reg <= 1'b0; // RL18
      end
    end
  end
endmodule // pric_top

// ---- dv/pric_props.sv ----
/* pric_props: port checks for pric_top.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/10ps
module pric_props (
  // clock and reset
  input wire logic        MCLK_IN,
  input wire logic        RST_IN,
  // core side
  input wire logic        ACCEPT_IN,
  input wire logic [20:0] RETURN_ADDR_IN,
  input wire logic        IRQ_OUT,
  input wire logic [20:0] VECTOR_OUT,
  input wire logic        PUSH_OUT,
  input wire logic [20:0] PUSH_ADDR_OUT,
  // register bus
  input wire logic        AWVALID_IN,
  input wire logic        AWREADY_OUT,
  input wire logic        WVALID_IN,
  input wire logic        WREADY_OUT,
  input wire logic        BVALID_OUT,
  input wire logic        BREADY_IN,
  input wire logic        ARVALID_IN,
  input wire logic        ARREADY_OUT,
  input wire logic        RVALID_OUT,
  input wire logic [31:0] RDATA_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);

  chk_push_cause: assert property (
    PUSH_OUT |-> $past(ACCEPT_IN) && $past(IRQ_OUT)
      && PUSH_ADDR_OUT == $past(RETURN_ADDR_IN))
    else $error("push without accept");
  chk_accept_drop: assert property (
    ACCEPT_IN && IRQ_OUT |=> PUSH_OUT && !IRQ_OUT)
    else $error("request stands after accept");
  chk_vec_legal: assert property (
    IRQ_OUT |-> VECTOR_OUT == 21'h000008 || VECTOR_OUT == 21'h000018)
    else $error("bad vector");
  chk_reset_idle: assert property (
    $fell(RST_IN) |-> !IRQ_OUT && !PUSH_OUT && VECTOR_OUT == 21'h000008)
    else $error("not idle after reset");
  chk_write_answer: assert property (
    AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT |=> BVALID_OUT)
    else $error("late write response");
  chk_read_answer: assert property (
    ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
    else $error("late read data");
  chk_resp_release: assert property (
    BVALID_OUT && BREADY_IN |=> !BVALID_OUT)
    else $error("response not released");
  chk_read_upper: assert property (
    RVALID_OUT |-> RDATA_OUT[31:8] == 24'h000000)
    else $error("upper read bits set");

  cov_low: cover property (ACCEPT_IN && IRQ_OUT && VECTOR_OUT == 21'h000018);
  cov_high: cover property (ACCEPT_IN && IRQ_OUT && VECTOR_OUT == 21'h000008);
  cov_push: cover property (PUSH_OUT);
endmodule // pric_props

bind pric_top pric_props u_props (.*);

// ---- dv/pric_core_model.sv ----
/* pric_core_model: core stand-in that takes each raised request.
   assumes the request stands until the accept strobe. */
`timescale 1ns/10ps
module pric_core_model (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // request side
  input  wire logic irq_in,
  input  wire logic slow_in,
  output logic      accept_out
);
  logic [2:0] wait_reg;

  // slow answers give a later request time to change what is served
  always @(posedge clk_in) begin
    if (rst_in || accept_out || !irq_in) begin
      accept_out <= 1'b0;
      wait_reg   <= 3'h0;
    end else if (wait_reg >= (slow_in ? 3'h5 : 3'h0)) begin
      accept_out <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 3'h1;
    end
  end
endmodule // pric_core_model

// ---- dv/pric_top_test.sv ----
/* pric_top_test: bench with bus master, event driver and vector queue.
   assumes pric_top and the core model beside it. */
`timescale 1ns/10ps
`include "pic_defines.vh"
module pric_top_test;
  localparam int LAT = 3;
  logic        clk = 0, rst = 1, cap1 = 0, cap2 = 0, slp = 0, rtn = 0, slow = 0;
  logic        acc, irq, push, wake, awready, wready, bvalid, arready, rvalid;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [2:0]  pins = 0;
  logic [1:0]  bresp, rresp;
  logic [7:0]  awaddr = 0, araddr = 0, v;
  logic [15:0] rnd = 16'd71;
  logic [20:0] raddr = 0, vec, paddr, pa;
  logic [31:0] wdata = 0, rdata;
  logic [20:0] expv[$];
  int          errors = 0, cmp_count = 0, n;

  always #12.5 clk = ~clk;

  pric_top #(.LATENCY(LAT)) DUT (.MCLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1),
    .EXT_PIN_IN(pins), .CAP1_EVENT_IN(cap1), .CAP2_EVENT_IN(cap2), .SLEEP_IN(slp),
    .RETURN_IN(rtn), .ACCEPT_IN(acc), .RETURN_ADDR_IN(raddr), .IRQ_OUT(irq),
    .VECTOR_OUT(vec), .PUSH_OUT(push), .PUSH_ADDR_OUT(paddr), .WAKE_OUT(wake),
    .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
    .WDATA_IN(wdata), .WSTRB_IN(4'hf), .WVALID_IN(wvalid), .WREADY_OUT(wready),
    .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
    .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
    .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready));
  pric_core_model u_core (.clk_in(clk), .rst_in(rst), .irq_in(irq),
    .slow_in(slow), .accept_out(acc));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ok;
    ok = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1;
    wvalid  <= 1;
    bready  <= 1;
    repeat (40) if (!ok) begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) begin
        bready <= 0;
        ok = 1;
        chk(bresp, er);
      end
    end
    chk(ok, 1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ok;
    ok = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1;
    rready  <= 1;
    repeat (40) if (!ok) begin
      @(posedge clk);
      if (arready) arvalid <= 0;
      if (rvalid) begin
        rready <= 0;
        ok = 1;
        chk(rdata, ed);
        chk(rresp, er);
      end
    end
    chk(ok, 1);
  endtask

  task automatic ret;
    @(posedge clk);
    rtn <= 1;
    @(posedge clk);
    rtn <= 0;
  endtask

  task automatic pin(input logic [2:0] b);
    @(posedge clk);
    pins <= pins ^ b;
  endtask

  task automatic drain;
    n = 0;
    while (expv.size() > 0 && n < 60) begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
    chk(expv.size(), 0);
  endtask

  always @(posedge clk) begin
    rnd   <= lfsr(rnd);
    raddr <= {5'h00, rnd};
    slow  <= rnd[4];
  end

  // every accept must match a queued expectation, so a stray request fails
  always @(posedge clk) if (!rst) begin
    if (push) chk(paddr, pa);
    if (acc && irq) begin
      pa = raddr;
      chk(expv.size() > 0, 1);
      if (expv.size() > 0) chk(vec, expv.pop_front());
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    rd(8'h00, 32'h70, 0);
    rd(8'h0c, 32'h07, 0);
    rd(8'h10, 32'h03, 0);
    rd(8'h1c, 32'h00, `PRIC_RESP_SLVERR);
    wr(8'h1c, 32'h5a, `PRIC_RESP_SLVERR);
    v = rnd[7:0];
    wr(8'h10, {24'h0, v}, 0);
    rd(8'h10, {30'h0, v[1:0]}, 0);
    @(posedge clk);
    cap1 <= 1;
    cap2 <= 1;
    @(posedge clk);
    cap1 <= 0;
    cap2 <= 0;
    rd(8'h04, 32'h18, 0);
    wr(8'h08, 32'h1f, 0);
    wr(8'h00, 32'h71, 0);
    repeat (20) @(posedge clk);
    expv.push_back(`PRIC_VEC_HIGH);
    wr(8'h00, 32'h73, 0);
    drain;
    rd(8'h00, 32'h72, 0);
    wr(8'h04, 32'h00, 0);
    ret;
    rd(8'h00, 32'h73, 0);
    expv.push_back(`PRIC_VEC_HIGH);
    pin(3'h1);
    n = 0;
    while (!irq && n < 20) begin
      @(posedge clk);
      n++;
    end
    // 3 to 4 cycles from event to request, plus one edge to see the pin and one to read irq
    chk(n >= 3 + 2 && n <= 4 + 2, 1);
    drain;
    wr(8'h04, 32'h00, 0);
    ret;
    pin(3'h1);
    repeat (20) @(posedge clk);
    wr(8'h0c, 32'h06, 0);
    wr(8'h00, 32'h77, 0);
    expv.push_back(`PRIC_VEC_LOW);
    pin(3'h1);
    drain;
    expv.push_back(`PRIC_VEC_HIGH);
    pin(3'h2);
    drain;
    rd(8'h18, 32'h06, 0);
    wr(8'h04, 32'h00, 0);
    ret;
    ret;
    rd(8'h00, 32'h77, 0);
    pin(3'h3);
    expv.push_back(`PRIC_VEC_HIGH);
    pin(3'h3);
    drain;
    wr(8'h04, 32'h01, 0);
    wr(8'h00, 32'h77, 0);
    repeat (20) @(posedge clk);
    expv.push_back(`PRIC_VEC_LOW);
    ret;
    drain;
    wr(8'h04, 32'h00, 0);
    ret;
    wr(8'h00, 32'h07, 0);
    pin(3'h4);
    repeat (20) @(posedge clk);
    expv.push_back(`PRIC_VEC_HIGH);
    pin(3'h4);
    drain;
    wr(8'h04, 32'h00, 0);
    ret;
    wr(8'h00, 32'h77, 0);
    @(posedge clk);
    slp <= 1;
    @(posedge clk);
    slp <= 0;
    expv.push_back(`PRIC_VEC_HIGH);
    pin(3'h4);
    n = 0;
    while (!wake && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(wake, 1);
    drain;
    complete_run;
  end

  initial begin
    repeat (6000) @(posedge clk);
    errors++;
    complete_run;
  end
endmodule // pric_top_test
